//--- hdl/loop_status_pkg.sv
// Shared constants, the condition priority encoder and its package
//
// Summary of operation
// - Instructions are accepted only while the device is an addressed listener.
// - Own listen address with remote enable active makes listener and remote mode.
// - Not remote enable message returns the device to local mode.
// - In remote mode, instructions dump control registers or dump character registers.
// - A dump instruction keeps registers ready until talker and send data arrive.
// - Own talk address ends listening and makes talker; send data starts output.
// - Each sent byte holds one register nibble, low bits, ascending register order.
// - After the last register byte an end of transmission OK message follows.
// - Four-byte status record is refreshed whenever a reported condition changes.
// - Status byte 1 bit 6 flags service request; clears on cause clear or status sent.
// - Status byte 1 shows only the highest active condition, then the next lower.
// - Priority 1: autodisconnect reported as 1X000101.
// - Priority 2: manual service key pressed since status sent, 1X001001.
// - Priority 3: serial break received since status sent, 1X001010.
// - Priority 4: receive data error reported as 1X000011.
// - Priority 5: receive buffer holding data reported as 1X100010.
// - Priority 6: transmit buffer not full reported as 1X100001.
// - Priority 7: transmit buffer full reported as 1X100011.
// - No service request unless bit 3 of enable register A is set.
// - Pending service request converts next passing data, end or identify message.
`default_nettype none
`timescale 1ns/10ps

package loop_status_pkg;

    typedef enum logic [3:0] {
        MK_DAB   = 4'h0,
        MK_END   = 4'h1,
        MK_IDY   = 4'h2,
        MK_LAD   = 4'h3,
        MK_TAD   = 4'h4,
        MK_UNL   = 4'h5,
        MK_UNT   = 4'h6,
        MK_REN   = 4'h7,
        MK_NRE   = 4'h8,
        MK_SDA   = 4'h9,
        MK_SST   = 4'ha,
        MK_EOT   = 4'hb,
        MK_OTHER = 4'hf
    } msg_e;

    localparam int          NUM_CTRL     = 16;
    localparam int          NUM_CHAR     = 16;
    localparam logic [3:0]  IDX_ENA_A    = 4'h0;
    localparam logic [3:0]  IDX_ENA_B    = 4'h1;
    localparam logic [3:0]  IDX_ENA_C    = 4'h2;
    localparam logic [3:0]  IDX_DISC     = 4'hd;
    localparam int          ENA_A_GLOBAL = 3;
    localparam int          ENA_A_DERR   = 2;
    localparam int          ENA_B_TXEMP  = 0;
    localparam int          ENA_B_TXNF   = 1;
    localparam int          ENA_B_RXNE   = 2;
    localparam int          ENA_B_RXFULL = 3;
    localparam int          ENA_C_BREAK  = 0;
    localparam int          ENA_C_DISC   = 1;
    localparam int          ENA_C_KEY    = 2;
    localparam logic [3:0]  DUMP_HI      = 4'h3;
    localparam logic [7:0]  CH_S         = 8'h53;
    localparam logic [7:0]  CH_R         = 8'h52;
    localparam logic [7:0]  CH_0         = 8'h30;
    localparam logic [7:0]  CH_2         = 8'h32;
    localparam logic [7:0]  CH_SEMI      = 8'h3b;
    localparam logic [7:0]  CH_CR        = 8'h0d;
    localparam logic [7:0]  CH_LF        = 8'h0a;
    localparam int          SRQ_BIT      = 6;
    localparam logic        SB1_TOP      = 1'b1;
    localparam logic [5:0]  SC_DISC      = 6'b000101;
    localparam logic [5:0]  SC_KEY       = 6'b001001;
    localparam logic [5:0]  SC_BREAK     = 6'b001010;
    localparam logic [5:0]  SC_DERR      = 6'b000011;
    localparam logic [5:0]  SC_RXDATA    = 6'b100010;
    localparam logic [5:0]  SC_TXROOM    = 6'b100001;
    localparam logic [5:0]  SC_TXFULL    = 6'b100011;
    localparam int          NUM_STAT     = 4;

endpackage

// ****************************************
// Highest-priority condition to status byte 1
// ****************************************
module cond_priority_enc (
    input  wire logic       srq,
    input  wire logic       disc,
    input  wire logic       key_seen,
    input  wire logic       brk_seen,
    input  wire logic       data_err,
    input  wire logic       rx_not_empty,
    input  wire logic       tx_full,
    output logic      [7:0] code
);
    logic [5:0] low;

    always_comb begin
        if (disc) begin
            low = loop_status_pkg::SC_DISC;
        end else if (key_seen) begin
            low = loop_status_pkg::SC_KEY;
        end else if (brk_seen) begin
            low = loop_status_pkg::SC_BREAK;
        end else if (data_err) begin
            low = loop_status_pkg::SC_DERR;
        end else if (rx_not_empty) begin
            low = loop_status_pkg::SC_RXDATA;
        end else if (!tx_full) begin
            low = loop_status_pkg::SC_TXROOM;
        end else begin
            low = loop_status_pkg::SC_TXFULL;
        end
        code = {loop_status_pkg::SB1_TOP, srq, low};
    end
endmodule // cond_priority_enc

`default_nettype wire

//--- hdl/remote_readback_and_status_priority.sv
// Remote-mode read-back, addressing and system status of the loop interface
`default_nettype none
`timescale 1ns/10ps

module remote_readback_and_status_priority (
    input  wire logic       MCLK,
    input  wire logic       RESET_N,
    input  wire logic [4:0] DEV_ADDR,
    input  wire logic       MSG_VALID,
    input  wire logic [3:0] MSG_KIND,
    input  wire logic [4:0] MSG_ADDR,
    input  wire logic [7:0] MSG_DATA,
    output logic            MSG_READY,
    output logic            OUT_VALID,
    output logic      [3:0] OUT_KIND,
    output logic      [7:0] OUT_DATA,
    output logic            OUT_SRQ,
    input  wire logic       OUT_READY,
    input  wire logic       CFG_WE,
    input  wire logic [4:0] CFG_ADDR,
    input  wire logic [3:0] CFG_DATA,
    input  wire logic       AUTODISC,
    input  wire logic       MANUAL_SERVICE_KEY,
    input  wire logic       BREAK_SEEN,
    input  wire logic       DATA_ERR,
    input  wire logic       RX_NOT_EMPTY,
    input  wire logic       RX_FULL,
    input  wire logic       TX_EMPTY,
    input  wire logic       TX_FULL,
    input  wire logic [23:0] STATUS_EXT,
    output logic      [7:0] SYS_STATUS,
    output logic            REMOTE,
    output logic            LISTENER,
    output logic            TALKER
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DUMP = 2'b01,
        ST_STAT = 2'b10,
        ST_EOT  = 2'b11
    } state_e;

    typedef enum logic [1:0] {
        ARM_NONE = 2'b00,
        ARM_CTRL = 2'b01,
        ARM_CHAR = 2'b10
    } arm_e;

    // ****************************************
    // Register storage
    // ****************************************
    logic [3:0]  ctrl_r [loop_status_pkg::NUM_CTRL];
    logic [3:0]  char_r [loop_status_pkg::NUM_CHAR];
    logic [7:0]  stat_r [loop_status_pkg::NUM_STAT];

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < loop_status_pkg::NUM_CTRL; i++) begin
                ctrl_r[i] <= 4'h0;
                char_r[i] <= 4'h0;
            end
        end else if (CFG_WE) begin
            if (CFG_ADDR[4]) begin
                char_r[CFG_ADDR[3:0]] <= CFG_DATA;
            end else begin
                ctrl_r[CFG_ADDR[3:0]] <= CFG_DATA;
            end
        end
    end

    // ****************************************
    // Manual key pin synchroniser
    // ****************************************
    logic key_s1_r, key_s2_r, key_s3_r, key_lvl_r, key_lvl_nxt, key_rise;

    always_comb begin
        key_lvl_nxt = (key_s2_r == key_s3_r) ? key_s3_r : key_lvl_r;
        key_rise    = key_s2_r & key_s3_r & ~key_lvl_r;
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            key_s1_r  <= 1'b0;
            key_s2_r  <= 1'b0;
            key_s3_r  <= 1'b0;
            key_lvl_r <= 1'b0;
        end else begin
            key_s1_r  <= MANUAL_SERVICE_KEY;
            key_s2_r  <= key_s1_r;
            key_s3_r  <= key_s2_r;
            key_lvl_r <= key_lvl_nxt;
        end
    end

    // ****************************************
    // Addressing, parser and talker sequencer
    // ****************************************
    state_e      st_r, st_nxt;
    arm_e        armed_r, armed_nxt;
    logic        ren_r, ren_nxt, remote_r, remote_nxt;
    logic        listen_r, listen_nxt, talk_r, talk_nxt;
    logic [23:0] cmd_r, cmd_nxt;
    logic [1:0]  cmd_cnt_r, cmd_cnt_nxt;
    logic [3:0]  idx_r, idx_nxt;
    logic        out_valid_nxt, out_srq_nxt, stat_done;
    logic [3:0]  out_kind_nxt;
    logic [7:0]  out_data_nxt;
    logic        take, own, hs, term, srq_r;
    loop_status_pkg::msg_e kind;

    always_comb begin
        take          = MSG_VALID & MSG_READY;
        kind          = loop_status_pkg::msg_e'(MSG_KIND);
        own           = (MSG_ADDR == DEV_ADDR);
        hs            = OUT_VALID & OUT_READY;
        term          = (MSG_DATA == loop_status_pkg::CH_SEMI) | (MSG_DATA == loop_status_pkg::CH_CR)
                      | (MSG_DATA == loop_status_pkg::CH_LF);
        st_nxt        = st_r;
        armed_nxt     = armed_r;
        ren_nxt       = ren_r;
        remote_nxt    = remote_r;
        listen_nxt    = listen_r;
        talk_nxt      = talk_r;
        cmd_nxt       = cmd_r;
        cmd_cnt_nxt   = cmd_cnt_r;
        idx_nxt       = idx_r;
        out_valid_nxt = OUT_VALID & ~OUT_READY;
        out_kind_nxt  = OUT_KIND;
        out_data_nxt  = OUT_DATA;
        out_srq_nxt   = OUT_SRQ & ~OUT_READY;
        stat_done     = 1'b0;
        if (take) begin
            case (kind)
                loop_status_pkg::MK_REN: ren_nxt = 1'b1;
                loop_status_pkg::MK_NRE: begin
                    ren_nxt    = 1'b0;
                    remote_nxt = 1'b0;
                end
                loop_status_pkg::MK_LAD: begin
                    listen_nxt = own;
                    if (own && ren_r) begin
                        remote_nxt = 1'b1;
                    end
                end
                loop_status_pkg::MK_UNL: listen_nxt = 1'b0;
                loop_status_pkg::MK_TAD: begin
                    talk_nxt = own;
                    if (own) begin
                        listen_nxt = 1'b0;
                    end
                end
                loop_status_pkg::MK_UNT: talk_nxt = 1'b0;
                loop_status_pkg::MK_SDA: begin
                    if (talk_r && armed_r != ARM_NONE) begin
                        st_nxt  = ST_DUMP;
                        idx_nxt = 4'h0;
                    end
                end
                loop_status_pkg::MK_SST: begin
                    if (talk_r) begin
                        st_nxt  = ST_STAT;
                        idx_nxt = 4'h0;
                    end
                end
                loop_status_pkg::MK_DAB, loop_status_pkg::MK_END: begin
                    if (listen_r && remote_r) begin
                        if (term) begin
                            if (cmd_cnt_r == 2'd3 && cmd_r[23:8] == {loop_status_pkg::CH_S, loop_status_pkg::CH_R}) begin
                                if (cmd_r[7:0] == loop_status_pkg::CH_0) begin
                                    armed_nxt = ARM_CTRL;
                                end else if (cmd_r[7:0] == loop_status_pkg::CH_2) begin
                                    armed_nxt = ARM_CHAR;
                                end
                            end
                            cmd_cnt_nxt = 2'd0;
                        end else begin
                            cmd_nxt = {cmd_r[15:0], MSG_DATA};
                            if (cmd_cnt_r != 2'd3) begin
                                cmd_cnt_nxt = cmd_cnt_r + 2'd1;
                            end
                        end
                    end else if (!talk_r) begin
                        out_valid_nxt = 1'b1;
                        out_kind_nxt  = MSG_KIND;
                        out_data_nxt  = MSG_DATA;
                        out_srq_nxt   = srq_r;
                    end
                end
                loop_status_pkg::MK_IDY: begin
                    out_valid_nxt = 1'b1;
                    out_kind_nxt  = MSG_KIND;
                    out_data_nxt  = MSG_DATA;
                    out_srq_nxt   = srq_r;
                end
                default: ;
            endcase
        end
        if (!out_valid_nxt) begin
            case (st_r)
                ST_DUMP: begin
                    out_valid_nxt = 1'b1;
                    out_kind_nxt  = loop_status_pkg::MK_DAB;
                    out_srq_nxt   = srq_r;
                    out_data_nxt  = {loop_status_pkg::DUMP_HI,
                                     (armed_r == ARM_CHAR) ? char_r[idx_r] : ctrl_r[idx_r]};
                    idx_nxt       = idx_r + 4'h1;
                    if (idx_r == 4'hf) begin
                        st_nxt = ST_EOT;
                    end
                end
                ST_STAT: begin
                    out_valid_nxt = 1'b1;
                    out_kind_nxt  = loop_status_pkg::MK_DAB;
                    out_srq_nxt   = srq_r;
                    out_data_nxt  = stat_r[idx_r[1:0]];
                    idx_nxt       = idx_r + 4'h1;
                    if (idx_r == 4'h3) begin
                        st_nxt    = ST_IDLE;
                        stat_done = 1'b1;
                    end
                end
                ST_EOT: begin
                    out_valid_nxt = 1'b1;
                    out_kind_nxt  = loop_status_pkg::MK_EOT;
                    out_data_nxt  = 8'h00;
                    out_srq_nxt   = 1'b0;
                    armed_nxt     = ARM_NONE;
                    st_nxt        = ST_IDLE;
                end
                default: ;
            endcase
        end
        if (!remote_nxt) begin
            armed_nxt = ARM_NONE;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r      <= ST_IDLE;
            armed_r   <= ARM_NONE;
            ren_r     <= 1'b0;
            remote_r  <= 1'b0;
            listen_r  <= 1'b0;
            talk_r    <= 1'b0;
            cmd_r     <= 24'h000000;
            cmd_cnt_r <= 2'd0;
            idx_r     <= 4'h0;
            OUT_VALID <= 1'b0;
            OUT_KIND  <= 4'h0;
            OUT_DATA  <= 8'h00;
            OUT_SRQ   <= 1'b0;
            MSG_READY <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            armed_r   <= armed_nxt;
            ren_r     <= ren_nxt;
            remote_r  <= remote_nxt;
            listen_r  <= listen_nxt;
            talk_r    <= talk_nxt;
            cmd_r     <= cmd_nxt;
            cmd_cnt_r <= cmd_cnt_nxt;
            idx_r     <= idx_nxt;
            OUT_VALID <= out_valid_nxt;
            OUT_KIND  <= out_kind_nxt;
            OUT_DATA  <= out_data_nxt;
            OUT_SRQ   <= out_srq_nxt;
            MSG_READY <= ~out_valid_nxt & (st_nxt == ST_IDLE);
        end
    end

    always_comb begin
        REMOTE   = remote_r;
        LISTENER = listen_r;
        TALKER   = talk_r;
    end

    // ****************************************
    // Status record and service request
    // ****************************************
    logic       key_seen_r, key_seen_nxt, brk_seen_r, brk_seen_nxt;
    logic       srq_nxt, srq_req, srq_req_q;
    logic [7:0] sb1;

    always_comb begin
        srq_req = ctrl_r[loop_status_pkg::IDX_ENA_A][loop_status_pkg::ENA_A_GLOBAL]
                & ((ctrl_r[loop_status_pkg::IDX_ENA_A][loop_status_pkg::ENA_A_DERR] & DATA_ERR)
                |  (ctrl_r[loop_status_pkg::IDX_ENA_B][loop_status_pkg::ENA_B_TXEMP] & TX_EMPTY)
                |  (ctrl_r[loop_status_pkg::IDX_ENA_B][loop_status_pkg::ENA_B_TXNF] & ~TX_FULL)
                |  (ctrl_r[loop_status_pkg::IDX_ENA_B][loop_status_pkg::ENA_B_RXNE] & RX_NOT_EMPTY)
                |  (ctrl_r[loop_status_pkg::IDX_ENA_B][loop_status_pkg::ENA_B_RXFULL] & RX_FULL)
                |  (ctrl_r[loop_status_pkg::IDX_ENA_C][loop_status_pkg::ENA_C_BREAK] & brk_seen_r)
                |  (ctrl_r[loop_status_pkg::IDX_ENA_C][loop_status_pkg::ENA_C_DISC] & AUTODISC)
                |  (ctrl_r[loop_status_pkg::IDX_ENA_C][loop_status_pkg::ENA_C_KEY] & key_seen_r));
        if (!srq_req) begin
            srq_nxt = 1'b0;
        end else if (!srq_req_q) begin
            srq_nxt = 1'b1;
        end else if (stat_done) begin
            srq_nxt = 1'b0;
        end else begin
            srq_nxt = srq_r;
        end
        key_seen_nxt = key_rise | (key_seen_r & ~stat_done);
        brk_seen_nxt = BREAK_SEEN | (brk_seen_r & ~stat_done);
    end

    cond_priority_enc u_enc (
        .srq          (srq_r),
        .disc         (AUTODISC),
        .key_seen     (key_seen_r),
        .brk_seen     (brk_seen_r),
        .data_err     (DATA_ERR),
        .rx_not_empty (RX_NOT_EMPTY),
        .tx_full      (TX_FULL),
        .code         (sb1)
    );

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            key_seen_r <= 1'b0;
            brk_seen_r <= 1'b0;
            srq_r      <= 1'b0;
            srq_req_q  <= 1'b0;
            SYS_STATUS <= 8'h00;
            for (int i = 0; i < loop_status_pkg::NUM_STAT; i++) begin
                stat_r[i] <= 8'h00;
            end
        end else begin
            key_seen_r <= key_seen_nxt;
            brk_seen_r <= brk_seen_nxt;
            srq_r      <= srq_nxt;
            srq_req_q  <= srq_req;
            SYS_STATUS <= sb1;
            stat_r[0]  <= sb1;
            stat_r[1]  <= STATUS_EXT[7:0];
            stat_r[2]  <= STATUS_EXT[15:8];
            stat_r[3]  <= STATUS_EXT[23:16];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Last register byte stands while the sequencer already waits to send the end message
    sequence s_last_dump;
        st_r == ST_EOT && OUT_VALID && OUT_KIND == loop_status_pkg::MK_DAB;
    endsequence

    property p_listen;
        @(posedge MCLK) disable iff (!RESET_N)
        take && kind == loop_status_pkg::MK_LAD && own && ren_r |=> listen_r && remote_r;
    endproperty
    a_listen: assert property (p_listen) else $error("own listen address did not enter remote");

    property p_local;
        @(posedge MCLK) disable iff (!RESET_N)
        take && kind == loop_status_pkg::MK_NRE |=> !REMOTE && armed_r == ARM_NONE;
    endproperty
    a_local: assert property (p_local) else $error("not remote enable ignored");

    property p_talk;
        @(posedge MCLK) disable iff (!RESET_N)
        take && kind == loop_status_pkg::MK_TAD && own |=> TALKER && !LISTENER;
    endproperty
    a_talk: assert property (p_talk) else $error("own talk address not honoured");

    property p_deaf;
        @(posedge MCLK) disable iff (!RESET_N)
        take && !listen_r && kind == loop_status_pkg::MK_DAB |=> armed_r == $past(armed_r);
    endproperty
    a_deaf: assert property (p_deaf) else $error("instruction taken while not listener");

    property p_nibble;
        @(posedge MCLK) disable iff (!RESET_N)
        st_r == ST_DUMP && !OUT_VALID && armed_r == ARM_CTRL
        |=> OUT_VALID && OUT_DATA == {loop_status_pkg::DUMP_HI, ctrl_r[$past(idx_r)]};
    endproperty
    a_nibble: assert property (p_nibble) else $error("dump byte wrong");

    property p_eot;
        @(posedge MCLK) disable iff (!RESET_N)
        s_last_dump ##0 hs |=> OUT_VALID && OUT_KIND == loop_status_pkg::MK_EOT;
    endproperty
    a_eot: assert property (p_eot) else $error("no end of transmission after last byte");

    property p_disc;
        @(posedge MCLK) disable iff (!RESET_N)
        AUTODISC |=> SYS_STATUS[5:0] == loop_status_pkg::SC_DISC && SYS_STATUS[7];
    endproperty
    a_disc: assert property (p_disc) else $error("autodisconnect not top priority");

    property p_gate;
        @(posedge MCLK) disable iff (!RESET_N)
        !ctrl_r[loop_status_pkg::IDX_ENA_A][loop_status_pkg::ENA_A_GLOBAL] |=> !srq_r ##1 !SYS_STATUS[6];
    endproperty
    a_gate: assert property (p_gate) else $error("service request without global enable");

    property p_conv;
        @(posedge MCLK) disable iff (!RESET_N)
        take && srq_r && (kind == loop_status_pkg::MK_IDY
            || (!talk_r && !(listen_r && remote_r)
                && (kind == loop_status_pkg::MK_DAB || kind == loop_status_pkg::MK_END)))
        |=> OUT_VALID && OUT_SRQ;
    endproperty
    a_conv: assert property (p_conv) else $error("passing message not marked");

endmodule // remote_readback_and_status_priority

`default_nettype wire

//--- verif/loop_ctrl_model.sv
// Loop controller model taking the messages that the interface sends
`default_nettype none
`timescale 1ns/10ps
module loop_ctrl_model (
    input  wire logic       clk,
    input  wire logic       out_valid,
    input  wire logic [3:0] out_kind,
    input  wire logic [7:0] out_data,
    input  wire logic       out_srq,
    output logic            out_ready
);
    logic [12:0] rx_q[$];
    // Stalls at random, so the sender must hold each message
    always @(posedge clk) begin
        if (out_valid && out_ready)
            rx_q.push_back({out_srq, out_kind, out_data});
        out_ready <= #1 ($urandom % 3) != 0;
    end
endmodule // loop_ctrl_model
`default_nettype wire

//--- verif/remote_readback_and_status_priority_tb.sv
// Self-checking bench of the remote read-back and status block
`default_nettype none
`timescale 1ns/10ps
module remote_readback_and_status_priority_tb;
    logic       clk = 0, rst_n = 0, mv = 0, we = 0, disc = 0, key = 0, brk = 0, derr = 0, rxne = 0, txf = 0;
    logic [3:0] mk = 0, cd = 0, ok, regs[16], cregs[16];
    logic [23:0] sx = 0;
    logic [4:0] ma = 0, ca = 0;
    logic [7:0] md = 0, sys, od;
    logic       mr, ov, os, ordy, rem, lsn, tlk;
    int         err_count = 0, check_count = 0;
    always #5 clk = ~clk;
    remote_readback_and_status_priority i_dut (.MCLK(clk), .RESET_N(rst_n), .DEV_ADDR(5'h03),
        .MSG_VALID(mv), .MSG_KIND(mk), .MSG_ADDR(ma), .MSG_DATA(md), .MSG_READY(mr),
        .OUT_VALID(ov), .OUT_KIND(ok), .OUT_DATA(od), .OUT_SRQ(os), .OUT_READY(ordy),
        .CFG_WE(we), .CFG_ADDR(ca), .CFG_DATA(cd), .AUTODISC(disc), .MANUAL_SERVICE_KEY(key),
        .BREAK_SEEN(brk), .DATA_ERR(derr), .RX_NOT_EMPTY(rxne), .RX_FULL(1'b0), .TX_EMPTY(1'b0),
        .TX_FULL(txf), .STATUS_EXT(sx), .SYS_STATUS(sys), .REMOTE(rem), .LISTENER(lsn),
        .TALKER(tlk));
    loop_ctrl_model i_ctl (.clk(clk), .out_valid(ov), .out_kind(ok), .out_data(od), .out_srq(os),
        .out_ready(ordy));
    task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (err_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic send(input loop_status_pkg::msg_e k, input logic [7:0] d);
        int n = 0;
        mk = k;
        ma = d[4:0];
        md = d;
        mv = 1'b1;
        @(posedge clk);
        while (!mr && n++ < 300) @(posedge clk);
        if (!mr) err_count++;
        #1 mv = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        ca = a;
        cd = d;
        we = 1'b1;
        @(posedge clk);
        #1 we = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic take(output logic [12:0] v);
        int n = 0;
        while (i_ctl.rx_q.size() == 0 && n++ < 500) @(posedge clk);
        #1;
        if (i_ctl.rx_q.size() == 0) err_count++;
        else v = i_ctl.rx_q.pop_front();
    endtask
    task automatic press;
        key = 1'b1;
        repeat (6) @(posedge clk);
        #1 key = 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic dump(input logic [7:0] c, input logic [7:0] t, input logic [3:0] v[16]);
        logic [12:0] g;
        send(loop_status_pkg::MK_LAD, 8'h03);
        check("lsn", {rem, lsn}, 2'b11);
        for (int i = 0; i < 4; i++) send(loop_status_pkg::MK_DAB, 8'({16'h5352, c, t} >> (24 - 8 * i)));
        send(loop_status_pkg::MK_TAD, 8'h03);
        check("tlk", {lsn, tlk}, 2'b01);
        send(loop_status_pkg::MK_SDA, 0);
        for (int i = 0; i < 16; i++) begin
            take(g);
            check("dump", g, {1'b0, loop_status_pkg::MK_DAB, 4'h3, v[i]});
        end
        take(g);
        check("eot", g, {1'b0, loop_status_pkg::MK_EOT, 8'h00});
        send(loop_status_pkg::MK_UNT, 0);
    endtask
    task automatic stat(input logic [7:0] s1);
        logic [12:0] g;
        send(loop_status_pkg::MK_TAD, 8'h03);
        send(loop_status_pkg::MK_SST, 0);
        for (int i = 0; i < 4; i++) begin
            take(g);
            check("stat", g, {s1[6], loop_status_pkg::MK_DAB, 8'({sx, s1} >> (8 * i))});
        end
        send(loop_status_pkg::MK_UNT, 0);
        repeat (4) @(posedge clk);
        #1 check("clr", sys, 8'ha1);
    endtask
    function automatic logic [7:0] sb1(input logic d, e, r, f);
        return {2'b10, d ? 6'b000101 : e ? 6'b000011 : r ? 6'b100010 : f ? 6'b100011 : 6'b100001};
    endfunction
    initial begin
        #200us;
        err_count++;
        give_verdict;
    end
    initial begin
        int i;
        logic [12:0] g;
        i = $urandom(32'h14dc);
        sx = 24'($urandom);
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1 check("sb1", sys, 8'ha1);
        for (i = 0; i < 40; i++) begin
            {disc, derr, rxne, txf} = 4'($urandom);
            repeat (3) @(posedge clk);
            #1 check("sb1", sys, sb1(disc, derr, rxne, txf));
        end
        {disc, derr, rxne, txf} = 4'h0;
        // Register A keeps its global enable off during the dump
        for (i = 0; i < 16; i++) begin
            regs[i] = (i == 0) ? 4'($urandom) & 4'h7 : 4'($urandom);
            cregs[i] = 4'($urandom);
            wr(5'(i), regs[i]);
            wr(5'(16 + i), cregs[i]);
        end
        send(loop_status_pkg::MK_UNL, 0);
        send(loop_status_pkg::MK_REN, 0);
        dump(8'h30, 8'h3b, regs);
        dump(8'h32, 8'h0a, cregs);
        send(loop_status_pkg::MK_NRE, 0);
        check("loc", {rem, tlk}, 2'b00);
        wr(5'h02, 4'h4);
        press;
        check("key", sys, 8'h89);
        stat(8'h89);
        brk = 1'b1;
        @(posedge clk);
        #1 brk = 1'b0;
        repeat (3) @(posedge clk);
        #1 check("brk", sys, 8'h8a);
        wr(5'h00, 4'h8);
        press;
        check("srq", sys, 8'hc9);
        send(loop_status_pkg::MK_DAB, 8'h41);
        take(g);
        check("pass", g, {1'b1, loop_status_pkg::MK_DAB, 8'h41});
        stat(8'hc9);
        give_verdict;
    end
endmodule // remote_readback_and_status_priority_tb
`default_nettype wire
